/* rtl/lai_pkg.sv */
// Constants and carrier types for the line alarm interrupt and error count block.
// Assumes one 40 MHz system clock and word-indexed register addressing.
package lai_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_FLAGS_ALARM_LOOP      = 6'h21;
    localparam logic [5:0] IDX_FLAGS_VIOLATION_ERROR = 6'h22;
    localparam logic [5:0] IDX_ERROR_COUNT_LOW       = 6'h23;
    localparam logic [5:0] IDX_ERROR_COUNT_HIGH      = 6'h24;
    localparam logic [5:0] IDX_EDGE_SELECT_REGISTER  = 6'h25;
    localparam logic [5:0] IDX_ERROR_CONTROL         = 6'h26;
    localparam logic [5:0] IDX_STATUS_REGISTER_ONE   = 6'h27;

    // Channel copy placement
    localparam logic [10:0] CH0_VIOLATION_BASE = 11'h7E2;
    localparam logic [10:0] CHN_VIOLATION_BASE = 11'h022;
    localparam logic [10:0] CHANNEL_STRIDE     = 11'h040;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_REMOTE_ALARM    = 7;
    localparam int BIT_LINE_ALARM      = 6;
    localparam int BIT_PATTERN_SYNC    = 5;
    localparam int BIT_LOOP_ACTIVATE   = 1;
    localparam int BIT_LOOP_DEACTIVATE = 0;
    localparam int BIT_SYS_BPV         = 5;
    localparam int BIT_LINE_BPV        = 4;
    localparam int BIT_SYS_EXZ         = 3;
    localparam int BIT_LINE_EXZ        = 2;
    localparam int BIT_PATTERN_ERROR   = 1;
    localparam int BIT_COUNTER_OVF     = 0;
    localparam int BIT_ALARM_EDGE      = 6;
    localparam int BIT_PATTERN_EDGE    = 5;
    localparam int BIT_LOOP_EDGE       = 0;
    localparam int BIT_COUNTING_MODE   = 1;
    localparam int BIT_MANUAL_UPDATE   = 0;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0]  RESET_BYTE      = 8'h00;
    localparam logic [15:0] RESET_COUNT     = 16'h0000;
    localparam int          CLK_HZ          = 40_000_000;
    localparam int          LOOP_SHORT_MS   = 40;
    localparam int          LOOP_E1_MS      = 30;
    localparam int          LOOP_LONG_MS    = 5_100;
    localparam int          ROUND_MS        = 1_000;
    localparam longint      LOOP_SHORT_CYC  = longint'(LOOP_SHORT_MS) * CLK_HZ / 1000;
    localparam longint      LOOP_E1_CYC     = longint'(LOOP_E1_MS) * CLK_HZ / 1000;
    localparam longint      LOOP_LONG_CYC   = longint'(LOOP_LONG_MS) * CLK_HZ / 1000;
    localparam longint      ROUND_CYC       = longint'(ROUND_MS) * CLK_HZ / 1000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic remote_alarm_state;
        logic line_alarm_state;
        logic pattern_sync_state;
        logic loop_activate_code;
        logic loop_deactivate_code;
    } lai_level_s;

    typedef struct packed {
        logic sys_bipolar_violation;
        logic line_bipolar_violation;
        logic sys_excess_zeros;
        logic line_excess_zeros;
        logic pattern_error;
        logic error_count_inc;
    } lai_event_s;

endpackage

/* rtl/lai_top.sv */
// Per-channel interrupt flags, loop-code persistence timers and error counter.
// Assumes detector levels and event pulses come from logic on clk_sys.
// Contract
// RQ1: Remote alarm flag sets on rise, or any edge when alarm edge select is 1.
// RQ2: Line alarm flag uses the same alarm edge select.
// RQ3: Pattern sync flag sets on rise, or any edge with pattern edge select.
// RQ4: Loop activate flag sets on rise, or any edge with loop-code edge select.
// RQ5: Loop deactivate flag uses the same loop-code edge select.
// RQ6: All flags reset to 0; writing 1 clears, writing 0 keeps.
// RQ7: Any set flag drives the interrupt output.
// RQ8: First flag register: bits 7,6,5,1,0 used; bits 4..2 reserved.
// RQ9: Second flag register: bits 5..0 used; bits 7..6 reserved.
// RQ10: Pattern error flag sets when the pattern checker reports an error.
// RQ11: Counter overflow flag sets when the 16-bit error counter overflows.
// RQ12: Count readable as low and high bytes, read only, reset zero.
// RQ13: Counting mode bit selects automatic or manual count capture.
// RQ14: Software reads the captured count before the next capture overwrites it.
// RQ15: Violation and count registers also exist per channel and for channel 0; the code decodes only the one 6-bit register map.
// RQ16: Activate status asserts after 40 ms, or 5.1 s with auto loopback.
// RQ17: Deactivate status after 40 ms T1/J1, 30 ms E1, or 5.1 s auto loopback.
// RQ18: A flag stays set until cleared; a set in the clearing cycle wins.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
module lai_top #(
    parameter int          CHANNEL     = 1,
    parameter logic [27:0] SHORT_CYC   = 28'(lai_pkg::LOOP_SHORT_CYC),
    parameter logic [27:0] E1_CYC      = 28'(lai_pkg::LOOP_E1_CYC),
    parameter logic [27:0] LONG_CYC    = 28'(lai_pkg::LOOP_LONG_CYC),
    parameter logic [27:0] ROUND_CYCLES = 28'(lai_pkg::ROUND_CYC)
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    // Avalon-MM slave, word addressed
    input  wire logic [5:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    // Detector side
    input  wire lai_pkg::lai_level_s det_level,
    input  wire lai_pkg::lai_event_s det_event,
    input  wire logic               automatic_loopback_enable,
    input  wire logic               e1_mode,
    // Interrupt output, high while any flag is set
    output logic                    irq_out
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic       ack_r;
    logic       wr_go;
    logic [7:0] wbyte;
    // Each request is answered in its second cycle; ack_r then blocks a repeat answer
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_go = avs_write & ack_r;
    assign wbyte = avs_writedata[7:0];

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] edge_sel_r;
    logic       count_mode_r;
    logic       manual_upd;
    assign manual_upd = wr_go && avs_address == lai_pkg::IDX_ERROR_CONTROL
                        && wbyte[lai_pkg::BIT_MANUAL_UPDATE];

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            edge_sel_r   <= lai_pkg::RESET_BYTE;
            count_mode_r <= 1'b0;
        end else if (wr_go) begin
            if (avs_address == lai_pkg::IDX_EDGE_SELECT_REGISTER) begin
                edge_sel_r <= wbyte;
            end
            if (avs_address == lai_pkg::IDX_ERROR_CONTROL) begin
                count_mode_r <= wbyte[lai_pkg::BIT_COUNTING_MODE];   // see RQ13
            end
        end
    end

    // ------------------------------------------------------------
    // Loop-code persistence timers
    // ------------------------------------------------------------
    logic [27:0] act_cnt_r;
    logic [27:0] deact_cnt_r;
    logic        act_state_r;
    logic        deact_state_r;
    logic [27:0] act_lim;
    logic [27:0] deact_lim;
    assign act_lim   = automatic_loopback_enable ? LONG_CYC : SHORT_CYC;   // see RQ16
    assign deact_lim = automatic_loopback_enable ? LONG_CYC :
                       (e1_mode ? E1_CYC : SHORT_CYC);                    // see RQ17

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            act_cnt_r   <= '0;
            act_state_r <= 1'b0;
        end else if (!det_level.loop_activate_code) begin
            act_cnt_r   <= '0;
            act_state_r <= 1'b0;
        end else if (act_cnt_r < act_lim) begin
            act_cnt_r <= act_cnt_r + 28'h000_0001;
        end else begin
            act_state_r <= 1'b1;                                   // see RQ16
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            deact_cnt_r   <= '0;
            deact_state_r <= 1'b0;
        end else if (!det_level.loop_deactivate_code) begin
            deact_cnt_r   <= '0;
            deact_state_r <= 1'b0;
        end else if (deact_cnt_r < deact_lim) begin
            deact_cnt_r <= deact_cnt_r + 28'h000_0001;
        end else begin
            deact_state_r <= 1'b1;                                 // see RQ17
        end
    end

    // ------------------------------------------------------------
    // Edge detection for level-type sources
    // ------------------------------------------------------------
    logic [4:0] lvl_now;
    logic [4:0] lvl_prev_r;
    logic [4:0] lvl_sel;
    logic [4:0] lvl_hit;
    assign lvl_now = {det_level.remote_alarm_state, det_level.line_alarm_state,
                      det_level.pattern_sync_state, act_state_r, deact_state_r};
    assign lvl_sel = {edge_sel_r[lai_pkg::BIT_ALARM_EDGE],    // see RQ1
                      edge_sel_r[lai_pkg::BIT_ALARM_EDGE],    // see RQ2
                      edge_sel_r[lai_pkg::BIT_PATTERN_EDGE],  // see RQ3
                      edge_sel_r[lai_pkg::BIT_LOOP_EDGE],     // see RQ4
                      edge_sel_r[lai_pkg::BIT_LOOP_EDGE]};    // see RQ5

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            // Idle level of every source, so no false edge follows reset
            lvl_prev_r <= '0;
        end else begin
            lvl_prev_r <= lvl_now;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_edge
            assign lvl_hit[g] = lvl_sel[g] ? (lvl_now[g] ^ lvl_prev_r[g])
                                           : (lvl_now[g] & ~lvl_prev_r[g]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Error counter and capture
    // ------------------------------------------------------------
    logic [15:0] err_cnt_r;
    logic [15:0] error_count_value_r;
    logic [27:0] round_cnt_r;
    logic        round_end;
    logic        capture;
    logic        cnt_ovf;
    assign round_end = round_cnt_r == ROUND_CYCLES - 28'h000_0001;
    assign capture   = count_mode_r ? round_end : manual_upd;          // see RQ13
    assign cnt_ovf   = det_event.error_count_inc && err_cnt_r == 16'hFFFF;  // see RQ11

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            round_cnt_r <= '0;
        end else if (round_end || !count_mode_r) begin
            round_cnt_r <= '0;
        end else begin
            round_cnt_r <= round_cnt_r + 28'h000_0001;
        end
    end

    // Capture overwrites the last value whether or not it was read
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            err_cnt_r           <= lai_pkg::RESET_COUNT;
            error_count_value_r <= lai_pkg::RESET_COUNT;
        end else if (capture) begin
            error_count_value_r <= err_cnt_r;                      // see RQ12, RQ14
            err_cnt_r <= {15'h0000, det_event.error_count_inc};
        end else if (det_event.error_count_inc) begin
            err_cnt_r <= err_cnt_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    logic [7:0] flags1_r;
    logic [7:0] flags2_r;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] clr1;
    logic [7:0] clr2;
    always_comb begin
        set1 = '0;
        set1[lai_pkg::BIT_REMOTE_ALARM]    = lvl_hit[4];
        set1[lai_pkg::BIT_LINE_ALARM]      = lvl_hit[3];
        set1[lai_pkg::BIT_PATTERN_SYNC]    = lvl_hit[2];
        set1[lai_pkg::BIT_LOOP_ACTIVATE]   = lvl_hit[1];
        set1[lai_pkg::BIT_LOOP_DEACTIVATE] = lvl_hit[0];   // see RQ8
        set2 = '0;
        set2[lai_pkg::BIT_SYS_BPV]       = det_event.sys_bipolar_violation;
        set2[lai_pkg::BIT_LINE_BPV]      = det_event.line_bipolar_violation;
        set2[lai_pkg::BIT_SYS_EXZ]       = det_event.sys_excess_zeros;
        set2[lai_pkg::BIT_LINE_EXZ]      = det_event.line_excess_zeros;
        set2[lai_pkg::BIT_PATTERN_ERROR] = det_event.pattern_error;   // see RQ10
        set2[lai_pkg::BIT_COUNTER_OVF]   = cnt_ovf;                   // see RQ9
    end
    assign clr1 = (wr_go && avs_address == lai_pkg::IDX_FLAGS_ALARM_LOOP) ? wbyte : '0;
    assign clr2 = (wr_go && avs_address == lai_pkg::IDX_FLAGS_VIOLATION_ERROR) ? wbyte : '0;

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flags1_r <= lai_pkg::RESET_BYTE;                       // see RQ6
            flags2_r <= lai_pkg::RESET_BYTE;
        end else begin
            // Set is applied after clear, so an event in the clearing cycle is kept
            flags1_r <= (flags1_r & ~clr1) | set1;                 // see RQ6, RQ18
            flags2_r <= (flags2_r & ~clr2) | set2;
        end
    end

    assign irq_out = |{flags1_r, flags2_r};                        // see RQ7

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb begin
        case (avs_address)
            lai_pkg::IDX_FLAGS_ALARM_LOOP:      rd_byte = flags1_r;
            lai_pkg::IDX_FLAGS_VIOLATION_ERROR: rd_byte = flags2_r;   // see RQ15
            lai_pkg::IDX_ERROR_COUNT_LOW:       rd_byte = error_count_value_r[7:0];
            lai_pkg::IDX_ERROR_COUNT_HIGH:      rd_byte = error_count_value_r[15:8];
            lai_pkg::IDX_EDGE_SELECT_REGISTER:  rd_byte = edge_sel_r;
            lai_pkg::IDX_ERROR_CONTROL:         rd_byte = {6'h00, count_mode_r, 1'b0};
            lai_pkg::IDX_STATUS_REGISTER_ONE:   rd_byte = {lvl_now[4:2], 3'h0, lvl_now[1:0]};
            default:                            rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

endmodule

/* verif/lai_top_asserts.sv */
// Port-level checker for the line alarm interrupt block.
// Assumes detector inputs stay quiet around reset release.
`timescale 1ns/1ps
module lai_top_asserts #(
    parameter logic [27:0] SHORT_CYC = 28'(lai_pkg::LOOP_SHORT_CYC)
) (
    // Clock and reset
    input wire logic                clk_sys,
    input wire logic                rstn,
    // Register bus
    input wire logic [5:0]          avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_readdata,
    input wire logic                avs_waitrequest,
    // Detector side and interrupt
    input wire lai_pkg::lai_level_s det_level,
    input wire lai_pkg::lai_event_s det_event,
    input wire logic                automatic_loopback_enable,
    input wire logic                irq_out
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic [27:0] act_cnt_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Cycles the activate code has been held with auto loopback off
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            act_cnt_r <= 28'h000_0000;
        end else if (det_level.loop_activate_code && !automatic_loopback_enable) begin
            act_cnt_r <= act_cnt_r + 28'h000_0001;
        end else begin
            act_cnt_r <= 28'h000_0000;
        end
    end

    sequence s_handshake;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence

    bus_handshake_a: assert property ($rose(avs_read || avs_write) |-> s_handshake)
        else $error("bus answer not in second request cycle");
    read_upper_zero_a: assert property (
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == '0)
        else $error("read data upper bits not zero");
    flags1_reserved_a: assert property (
        avs_read && !avs_waitrequest && avs_address == lai_pkg::IDX_FLAGS_ALARM_LOOP
        |-> avs_readdata[4:2] == 3'h0) else $error("reserved flag bits 4..2 set");
    flags2_reserved_a: assert property (
        avs_read && !avs_waitrequest && avs_address == lai_pkg::IDX_FLAGS_VIOLATION_ERROR
        |-> avs_readdata[7:6] == 2'h0) else $error("reserved flag bits 7..6 set");
    remote_rise_a: assert property ($rose(det_level.remote_alarm_state) |=> irq_out)
        else $error("remote alarm rise did not raise irq");
    line_rise_a: assert property ($rose(det_level.line_alarm_state) |=> irq_out)
        else $error("line alarm rise did not raise irq");
    pattern_rise_a: assert property ($rose(det_level.pattern_sync_state) |=> irq_out)
        else $error("pattern sync rise did not raise irq");
    event_irq_a: assert property (det_event[5:1] != '0 |=> irq_out)
        else $error("event pulse did not raise irq");
    irq_hold_a: assert property (irq_out && !avs_write |=> irq_out)
        else $error("irq dropped without a clearing write");
    irq_cause_a: assert property ($rose(irq_out) |-> $past(det_event) != '0
        || $past(det_level) != $past(det_level, 2) || $past(det_level.loop_activate_code)
        || $past(det_level.loop_deactivate_code)
        || $past(det_level, 2) != $past(det_level, 3)) else $error("irq rose without cause");
    loop_timer_a: assert property (act_cnt_r == SHORT_CYC + 28'h000_0004 |-> irq_out)
        else $error("activate code persistence did not raise irq");
endmodule

bind lai_top lai_top_asserts #(.SHORT_CYC(SHORT_CYC)) u_chk (
    .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .det_level(det_level), .det_event(det_event),
    .automatic_loopback_enable(automatic_loopback_enable), .irq_out(irq_out));

/* verif/testbench.sv */
// Self-checking bench for the line alarm interrupt block.
// Assumes the package is compiled first and the checker is bound to lai_top.
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                clk_sys       = 1'b0;
    logic                rstn          = 1'b0;
    logic [5:0]          avs_address   = 6'h00;
    logic                avs_read      = 1'b0;
    logic                avs_write     = 1'b0;
    logic [31:0]         avs_writedata = 32'h0000_0000;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    lai_pkg::lai_level_s det_level     = '0;
    lai_pkg::lai_event_s det_event     = '0;
    logic                auto_lp       = 1'b0;
    logic                e1_mode       = 1'b1;
    logic                irq_out;
    logic [7:0]          rd;
    int                  miscompares   = 0;
    int                  cmp_count     = 0;
    int                  cycles        = 0;
    int                  lp_code [7]   = '{0, 0, 1, 1, 0, 0, 0};
    int                  lp_auto [7]   = '{0, 0, 1, 0, 1, 0, 0};
    int                  lp_hold [7]   = '{5, 12, 16, 16, 40, 10, 11};
    int                  lp_exp  [7]   = '{0, 1, 0, 1, 1, 0, 1};
    int                  lp_e1   [7]   = '{1, 1, 1, 1, 1, 0, 0};

    lai_top #(
        .SHORT_CYC(28'h000_000A), .E1_CYC(28'h000_0008),
        .LONG_CYC(28'h000_001E), .ROUND_CYCLES(28'h000_0032)
    ) u_dut (
        .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .det_level(det_level), .det_event(det_event),
        .automatic_loopback_enable(auto_lp), .e1_mode(e1_mode), .irq_out(irq_out));

    always #12.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Waitrequest and read data are taken at the rising edge; only the timeout ends a wait
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write     <= wr;
        avs_read      <= ~wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [5:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(name, {24'h00_0000, rd}, {24'h00_0000, exp});
    endtask

    function automatic logic exp_set(input logic prev, input logic cur, input logic any);
        return any ? (prev != cur) : (!prev && cur);
    endfunction

    // Toggle one alarm or sync level, check flag, keep on write 0, clear on write 1
    task automatic lvl(input int i, input logic any);
        logic       prev;
        logic [7:0] e;
        prev = det_level[i];
        e    = exp_set(prev, ~prev, any) ? (8'h01 << (i + 3)) : 8'h00;
        @(posedge clk_sys);
        det_level[i] <= ~prev;
        repeat (2) @(posedge clk_sys);
        rdchk("flags_alarm_loop", lai_pkg::IDX_FLAGS_ALARM_LOOP, e);
        chk("irq_out", 32'(irq_out), 32'(e != 8'h00));
        bus(1'b1, lai_pkg::IDX_FLAGS_ALARM_LOOP, 8'h00);
        rdchk("flags_keep", lai_pkg::IDX_FLAGS_ALARM_LOOP, e);
        bus(1'b1, lai_pkg::IDX_FLAGS_ALARM_LOOP, e);
        rdchk("flags_clear", lai_pkg::IDX_FLAGS_ALARM_LOOP, 8'h00);
    endtask

    task automatic pulse(input int n);
        @(posedge clk_sys);
        det_event.error_count_inc <= 1'b1;
        repeat (n) @(posedge clk_sys);
        det_event.error_count_inc <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] cnt;
        void'($urandom(32'hc547));
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        for (int k = 0; k < 4; k++) begin
            rdchk("reset_value", lai_pkg::IDX_FLAGS_ALARM_LOOP + 6'(k), 8'h00);
        end
        rdchk("unmapped", 6'h3F, 8'h00);
        for (int es = 0; es < 2; es++) begin
            bus(1'b1, lai_pkg::IDX_EDGE_SELECT_REGISTER, es ? 8'h61 : 8'h00);
            for (int n = 0; n < 8; n++) begin
                lvl(2 + $urandom_range(2), es[0]);
            end
        end
        bus(1'b1, lai_pkg::IDX_EDGE_SELECT_REGISTER, 8'h00);
        det_level <= '0;
        bus(1'b1, lai_pkg::IDX_FLAGS_ALARM_LOOP, 8'hFF);
        for (int k = 0; k < 7; k++) begin
            @(posedge clk_sys);
            auto_lp                <= lp_auto[k][0];
            e1_mode                <= lp_e1[k][0];
            det_level[lp_code[k]] <= 1'b1;
            repeat (lp_hold[k]) @(posedge clk_sys);
            det_level[lp_code[k]] <= 1'b0;
            repeat (3) @(posedge clk_sys);
            rdchk("loop_flag", lai_pkg::IDX_FLAGS_ALARM_LOOP,
                  lp_exp[k] ? (8'h01 << lp_code[k]) : 8'h00);
            bus(1'b1, lai_pkg::IDX_FLAGS_ALARM_LOOP, 8'hFF);
        end
        // Any-edge loop select: a falling deactivate status sets the flag again
        bus(1'b1, lai_pkg::IDX_EDGE_SELECT_REGISTER, 8'h01);
        @(posedge clk_sys);
        det_level.loop_deactivate_code <= 1'b1;
        repeat (14) @(posedge clk_sys);
        bus(1'b1, lai_pkg::IDX_FLAGS_ALARM_LOOP, 8'hFF);
        det_level.loop_deactivate_code <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rdchk("loop_fall", lai_pkg::IDX_FLAGS_ALARM_LOOP, 8'h01);
        bus(1'b1, lai_pkg::IDX_FLAGS_ALARM_LOOP, 8'hFF);
        for (int j = 1; j < 6; j++) begin
            @(posedge clk_sys);
            det_event[j] <= 1'b1;
            @(posedge clk_sys);
            det_event[j] <= 1'b0;
            rdchk("flags_violation", lai_pkg::IDX_FLAGS_VIOLATION_ERROR, 8'h01 << j);
            chk("irq_out", 32'(irq_out), 32'h0000_0001);
            bus(1'b1, lai_pkg::IDX_FLAGS_VIOLATION_ERROR, 8'h01 << j);
            rdchk("flags_violation", lai_pkg::IDX_FLAGS_VIOLATION_ERROR, 8'h00);
        end
        cnt = 16'(1 + $urandom_range(300));
        pulse(int'(cnt));
        bus(1'b1, lai_pkg::IDX_ERROR_CONTROL, 8'h01);
        rdchk("count_low", lai_pkg::IDX_ERROR_COUNT_LOW, cnt[7:0]);
        rdchk("count_high", lai_pkg::IDX_ERROR_COUNT_HIGH, cnt[15:8]);
        bus(1'b1, lai_pkg::IDX_ERROR_COUNT_LOW, 8'hFF);
        rdchk("count_low_ro", lai_pkg::IDX_ERROR_COUNT_LOW, cnt[7:0]);
        pulse(65536);
        bus(1'b1, lai_pkg::IDX_ERROR_CONTROL, 8'h01);
        rdchk("count_wrap", lai_pkg::IDX_ERROR_COUNT_HIGH, 8'h00);
        rdchk("overflow_flag", lai_pkg::IDX_FLAGS_VIOLATION_ERROR, 8'h01);
        // Automatic rounds of 50 cycles: capture at the first round end, then overwrite
        bus(1'b1, lai_pkg::IDX_ERROR_CONTROL, 8'h02);
        cnt = 16'(1 + $urandom_range(40));
        pulse(int'(cnt));
        repeat (50) @(posedge clk_sys);
        rdchk("count_auto", lai_pkg::IDX_ERROR_COUNT_LOW, cnt[7:0]);
        repeat (50) @(posedge clk_sys);
        rdchk("count_overwrite", lai_pkg::IDX_ERROR_COUNT_LOW, 8'h00);
        results();
    end
endmodule
